//--- mpu_pkg.sv
// constants, field layouts and reset values of the bus memory protection unit
package mpu_pkg;
   // geometry
   localparam int NUM_DESC = 16;
   localparam int DESC_IDX_W = 4;
   localparam int NUM_PORTS = 2;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int GRAN_LSB = 5;
   localparam int GADDR_W = ADDR_W - GRAN_LSB;
   localparam logic [GRAN_LSB-1:0] GRAN_FILL = 5'h1f;
   // monitored slave ports
   localparam int PORT_SRAM = 0;
   localparam int PORT_PERIPH = 1;
   // crossbar master identifiers
   localparam int MST_W = 3;
   localparam logic [MST_W-1:0] MST_CORE_I = 3'h0;
   localparam logic [MST_W-1:0] MST_CORE_D = 3'h1;
   localparam logic [MST_W-1:0] MST_DMA = 3'h2;
   localparam logic [MST_W-1:0] MST_NET = 3'h3;
   localparam logic [MST_W-1:0] MST_EXT = 3'h4;
   localparam int NUM_NC = 3;
   // descriptor word select
   localparam logic [1:0] WORD_START = 2'h0;
   localparam logic [1:0] WORD_END = 2'h1;
   localparam logic [1:0] WORD_ACC = 2'h2;
   localparam logic [1:0] WORD_VALID = 2'h3;
   // access control word layout
   localparam int ACC_W = 12;
   localparam int ACC_UX = 0;
   localparam int ACC_UW = 1;
   localparam int ACC_UR = 2;
   localparam int ACC_SX = 3;
   localparam int ACC_SW = 4;
   localparam int ACC_SR = 5;
   localparam int ACC_NC_LSB = 6;
   localparam int VALID_BIT = 0;
   // error record layout
   localparam int ERR_W = 64;
   localparam int ERR_WR_BIT = 32;
   localparam int ERR_IF_BIT = 33;
   localparam int ERR_SUP_BIT = 34;
   localparam int ERR_MST_LSB = 35;
   localparam int ERR_PAD_W = 10;
   localparam int ERR_HIT_LSB = 48;
   // reset values
   localparam logic ENABLE_RST = 1'b0;
   localparam logic [GADDR_W-1:0] GADDR_RST = 27'h0000000;
   localparam logic [ACC_W-1:0] ACC_RST = 12'h000;
endpackage

//--- mpu_region_check.sv
// combinational check of one access against all region descriptors
`timescale 1ns/100ps
`default_nettype none
module mpu_region_check
   import mpu_pkg::*;
(
   // access under test
   input wire logic [ADDR_W-1:0] addr,
   input wire logic write,
   input wire logic instr,
   input wire logic supervisor,
   input wire logic [MST_W-1:0] master,
   // descriptor table
   input wire logic [NUM_DESC-1:0][GADDR_W-1:0] desc_start,
   input wire logic [NUM_DESC-1:0][GADDR_W-1:0] desc_end,
   input wire logic [NUM_DESC-1:0][ACC_W-1:0] desc_acc,
   input wire logic [NUM_DESC-1:0] desc_valid,
   // verdict
   output logic [NUM_DESC-1:0] hit_mask,
   output logic granted
);
   logic [GADDR_W-1:0] gaddr; // access address in 32-byte granules
   logic is_core; // request from either core bus
   logic [ACC_W-1:0] need; // one-hot permission bit this access needs

   assign gaddr = addr[ADDR_W-1:GRAN_LSB];
   assign is_core = (master == MST_CORE_I) || (master == MST_CORE_D);

   // select the single permission bit required
   always_comb begin
      need = '0;
      if (is_core) begin
         // core: supervisor and user sets kept apart
         if (write) begin
            need[supervisor ? ACC_SW : ACC_UW] = 1'b1;
         end else if (instr) begin
            need[supervisor ? ACC_SX : ACC_UX] = 1'b1;
         end else begin
            need[supervisor ? ACC_SR : ACC_UR] = 1'b1;
         end
      end else begin
         // other masters: read/write pair only, fetch counts as read
         for (int m = 0; m < NUM_NC; m++) begin
            if (master == MST_DMA + MST_W'(m)) begin
               need[ACC_NC_LSB + 2*m + (write ? 1 : 0)] = 1'b1;
            end
         end
      end
   end

   // every descriptor compared at once; any grant wins
   always_comb begin
      granted = 1'b0;
      hit_mask = '0;
      for (int d = 0; d < NUM_DESC; d++) begin
         // inclusive bounds on granule addresses
         hit_mask[d] = desc_valid[d] && (gaddr >= desc_start[d]) && (gaddr <= desc_end[d]);
         if (hit_mask[d] && ((desc_acc[d] & need) != '0)) begin
            granted = 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

//--- bus_memory_protection_unit.sv
// memory protection unit on the sram and peripheral bridge crossbar ports
`timescale 1ns/100ps
`default_nettype none
module bus_memory_protection_unit
   import mpu_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // global enable control
   input wire logic enable_we,
   input wire logic enable_wdata,
   output logic enabled,
   // descriptor programming port
   input wire logic cfg_we,
   input wire logic cfg_alias,
   input wire logic [DESC_IDX_W-1:0] cfg_desc,
   input wire logic [1:0] cfg_word,
   input wire logic [DATA_W-1:0] cfg_wdata,
   input wire logic cfg_re,
   output logic [DATA_W-1:0] cfg_rdata,
   // requests from the crossbar_switch, one lane per slave port
   input wire logic [NUM_PORTS-1:0] req_valid,
   input wire logic [NUM_PORTS-1:0][ADDR_W-1:0] req_addr,
   input wire logic [NUM_PORTS-1:0] req_write,
   input wire logic [NUM_PORTS-1:0] req_instr,
   input wire logic [NUM_PORTS-1:0] req_super,
   input wire logic [NUM_PORTS-1:0][MST_W-1:0] req_master,
   // cycles forwarded to the target slave
   output logic [NUM_PORTS-1:0] fwd_valid,
   output logic [NUM_PORTS-1:0][ADDR_W-1:0] fwd_addr,
   output logic [NUM_PORTS-1:0] fwd_write,
   output logic [NUM_PORTS-1:0] fwd_instr,
   output logic [NUM_PORTS-1:0] fwd_super,
   output logic [NUM_PORTS-1:0][MST_W-1:0] fwd_master,
   // error answer and error records
   output logic [NUM_PORTS-1:0] err_resp,
   output logic [NUM_PORTS-1:0] err_logged,
   output logic [NUM_PORTS-1:0][ERR_W-1:0] err_record
);
   // timing in short: a request is judged in the cycle it is offered
   // and answered from flops on the next edge, so fwd_valid or err_resp
   // follows req_valid by exactly one cycle, never both at once
   // reading the table has no side effects; a read only loads rdata_ff
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic enable_ff; // global checking enable
   // descriptor table, one row per entry
   logic [NUM_DESC-1:0][GADDR_W-1:0] start_ff; // region start granule
   logic [NUM_DESC-1:0][GADDR_W-1:0] end_ff; // region end granule
   logic [NUM_DESC-1:0][ACC_W-1:0] acc_ff; // access control words
   logic [NUM_DESC-1:0] valid_ff; // descriptor valid bits
   logic [DATA_W-1:0] rdata_ff; // descriptor read data
   logic [DATA_W-1:0] nxt_rdata; // read data mux result

   // per port pipeline registers
   // forwarded cycle toward the slave
   logic [NUM_PORTS-1:0] fwd_valid_ff;
   logic [NUM_PORTS-1:0][ADDR_W-1:0] fwd_addr_ff;
   logic [NUM_PORTS-1:0] fwd_write_ff;
   logic [NUM_PORTS-1:0] fwd_instr_ff;
   logic [NUM_PORTS-1:0] fwd_super_ff;
   logic [NUM_PORTS-1:0][MST_W-1:0] fwd_master_ff;
   // answer and record toward the crossbar
   logic [NUM_PORTS-1:0] err_resp_ff;
   logic [NUM_PORTS-1:0] err_logged_ff;
   logic [NUM_PORTS-1:0][ERR_W-1:0] err_record_ff;

   // per port verdicts
   // combinational; hit_mask and granted straight from the region checkers, fault also from req_valid and enable_ff
   logic [NUM_PORTS-1:0][NUM_DESC-1:0] hit_mask; // regions hit by access
   logic [NUM_PORTS-1:0] granted; // some region grants the access
   logic [NUM_PORTS-1:0] fault; // access must be stopped

   // ------------------------------------------------------------
   // global enable
   // ------------------------------------------------------------

   // comes up disabled so that boot code runs unrestricted
   // a write counts from the next edge on; a request on the
   // same edge is still judged by the old setting
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         enable_ff <= ENABLE_RST;
      end else if (enable_we) begin
         enable_ff <= enable_wdata;
      end
   end

   // ------------------------------------------------------------
   // descriptor storage, one slice per entry
   // ------------------------------------------------------------
   // one slice per entry keeps the write decode local; entries are
   // only touched by the word port, never by the checking lanes
   genvar gd;
   generate
      for (gd = 0; gd < NUM_DESC; gd++) begin : g_desc
         // write decode for this entry
         logic sel; // this entry addressed by the write port
         assign sel = cfg_we && (cfg_desc == DESC_IDX_W'(gd));

         // region bounds, written through the normal view only
         // bounds hold granule numbers; low five bits never stored
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               start_ff[gd] <= GADDR_RST;
               end_ff[gd] <= GADDR_RST;
            end else if (sel && !cfg_alias) begin
               // the alias view never reaches the bounds
               if (cfg_word == WORD_START) begin
                  start_ff[gd] <= cfg_wdata[DATA_W-1:GRAN_LSB];
               end else if (cfg_word == WORD_END) begin
                  end_ff[gd] <= cfg_wdata[DATA_W-1:GRAN_LSB];
               end
            end
         end

         // access control word, reachable from both views
         // a rights change through the alias view never withdraws the entry
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               acc_ff[gd] <= ACC_RST;
            end else if (sel && (cfg_alias || cfg_word == WORD_ACC)) begin
               acc_ff[gd] <= cfg_wdata[ACC_W-1:0];
            end
         end

         // valid bit dropped by hardware while the entry is rewritten
         // cleared on the first bound write, so a half written entry
         // can never match; the valid word re-arms it at the end
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               valid_ff[gd] <= 1'b0;
            end else if (sel && !cfg_alias) begin
               if (cfg_word == WORD_VALID) begin
                  // last word written: entry goes live as programmed
                  valid_ff[gd] <= cfg_wdata[VALID_BIT];
               end else begin
                  // any other normal-view word: entry withdrawn meanwhile
                  valid_ff[gd] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // descriptor read back
   // ------------------------------------------------------------

   // pick the addressed word; the alias view returns the access word
   // a write and a read on one edge return the old contents
   always_comb begin
      nxt_rdata = '0;
      if (cfg_alias) begin
         nxt_rdata = {{(DATA_W-ACC_W){1'b0}}, acc_ff[cfg_desc]};
      end else begin
         case (cfg_word)
            WORD_START: begin
               // start bound reads back as first byte of its granule
               nxt_rdata = {start_ff[cfg_desc], {GRAN_LSB{1'b0}}};
            end
            WORD_END: begin
               // end bound reads back as last byte of its granule
               nxt_rdata = {end_ff[cfg_desc], GRAN_FILL};
            end
            WORD_ACC: begin
               // same word as the alias view
               nxt_rdata = {{(DATA_W-ACC_W){1'b0}}, acc_ff[cfg_desc]};
            end
            default: begin
               // valid word: only bit zero means anything
               nxt_rdata = {{(DATA_W-1){1'b0}}, valid_ff[cfg_desc]};
            end
         endcase
      end
   end

   // read data registered and held between reads
   // software may pick it up any time after the read strobe
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= '0;
      end else if (cfg_re) begin
         rdata_ff <= nxt_rdata;
      end
   end

   // ------------------------------------------------------------
   // per slave port checking and forwarding
   // ------------------------------------------------------------
   // the two lanes share the table and the enable, nothing else: a fault on
   // one lane never stalls or answers the other
   genvar gp;
   generate
      for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port

         // both ports judged in parallel against the whole table
         // one checker copy per lane, so neither lane waits
         mpu_region_check u_check (
            .addr(req_addr[gp]),
            .write(req_write[gp]),
            .instr(req_instr[gp]),
            .supervisor(req_super[gp]),
            .master(req_master[gp]),
            .desc_start(start_ff),
            .desc_end(end_ff),
            .desc_acc(acc_ff),
            .desc_valid(valid_ff),
            .hit_mask(hit_mask[gp]),
            .granted(granted[gp])
         );

         // unmapped or denied, only while checking is enabled
         // masters without permission columns always fault
         assign fault[gp] = req_valid[gp] && enable_ff && !granted[gp];

         // cycle to the slave; faulting cycles never leave
         // a refused access shows nothing to the slave, so it
         // cannot start any side effect there
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               fwd_valid_ff[gp] <= 1'b0;
            end else begin
               fwd_valid_ff[gp] <= req_valid[gp] && !fault[gp];
            end
         end

         // address and attributes pass through unaltered
         // loaded by forwarded cycles only; refused ones leave no trace
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               fwd_addr_ff[gp] <= '0;
               fwd_write_ff[gp] <= 1'b0;
               fwd_instr_ff[gp] <= 1'b0;
               fwd_super_ff[gp] <= 1'b0;
               fwd_master_ff[gp] <= '0;
            end else if (req_valid[gp] && !fault[gp]) begin
               fwd_addr_ff[gp] <= req_addr[gp];
               fwd_write_ff[gp] <= req_write[gp];
               fwd_instr_ff[gp] <= req_instr[gp];
               fwd_super_ff[gp] <= req_super[gp];
               fwd_master_ff[gp] <= req_master[gp];
            end
         end

         // one-cycle error answer back through the crossbar
         // the crossbar ends the master's access on this pulse
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               err_resp_ff[gp] <= 1'b0;
            end else begin
               err_resp_ff[gp] <= fault[gp];
            end
         end

         // error record: overwritten by each new fault only
         // no clear path on purpose: reading it must not lose it,
         // a later fault on the same lane simply replaces it
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               err_record_ff[gp] <= '0;
            end else if (fault[gp]) begin
               // hit mask zero means unmapped, else all hits denied
               // attributes kept exactly as the master offered them
               err_record_ff[gp] <= {hit_mask[gp],
                                     {ERR_PAD_W{1'b0}},
                                     req_master[gp],
                                     req_super[gp],
                                     req_instr[gp],
                                     req_write[gp],
                                     req_addr[gp]};
            end
         end

         // record holds content once any fault was seen
         // tells software a real fault, not reset zeros, is stored
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               err_logged_ff[gp] <= 1'b0;
            end else if (fault[gp]) begin
               err_logged_ff[gp] <= 1'b1;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // outputs, all straight from flops
   // plain wires from the registers above, no logic after them
   // ------------------------------------------------------------
   assign enabled = enable_ff;
   assign cfg_rdata = rdata_ff;
   assign fwd_valid = fwd_valid_ff;
   assign fwd_addr = fwd_addr_ff;
   assign fwd_write = fwd_write_ff;
   assign fwd_instr = fwd_instr_ff;
   assign fwd_super = fwd_super_ff;
   assign fwd_master = fwd_master_ff;
   assign err_resp = err_resp_ff;
   assign err_logged = err_logged_ff;
   assign err_record = err_record_ff;
endmodule
`default_nettype wire

//--- mpu_properties.sv
// concurrent checks on the ports of the memory protection unit
`timescale 1ns/100ps
`default_nettype none
module mpu_properties
   import mpu_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // global enable
   input wire logic enable_we,
   input wire logic enable_wdata,
   input wire logic enabled,
   // request and answer lanes
   input wire logic [NUM_PORTS-1:0] req_valid,
   input wire logic [NUM_PORTS-1:0][ADDR_W-1:0] req_addr,
   input wire logic [NUM_PORTS-1:0] fwd_valid,
   input wire logic [NUM_PORTS-1:0][ADDR_W-1:0] fwd_addr,
   input wire logic [NUM_PORTS-1:0] err_resp,
   input wire logic [NUM_PORTS-1:0] err_logged,
   input wire logic [NUM_PORTS-1:0][ERR_W-1:0] err_record
);
   // all checks on the one bus clock
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   a_sram_one_answer: assert property (req_valid[0] |=> fwd_valid[0] != err_resp[0])
      else $error("sram request without exactly one answer");
   a_periph_one_answer: assert property (req_valid[1] |=> fwd_valid[1] != err_resp[1])
      else $error("bridge request without exactly one answer");
   a_no_idle_answer: assert property (!req_valid[0] |=> !(fwd_valid[0] || err_resp[0]))
      else $error("answer without request on sram lane");
   a_off_passes: assert property (!enabled && req_valid[1] |=> fwd_valid[1] && !err_resp[1])
      else $error("disabled unit blocked a request");
   a_fwd_same_addr: assert property (fwd_valid[0] |-> fwd_addr[0] == $past(req_addr[0]))
      else $error("forwarded address differs from request");
   a_err_logs_addr: assert property (err_resp[1] |-> err_logged[1]
      && err_record[1][31:0] == $past(req_addr[1]))
      else $error("error record lacks faulting address");
   a_record_held: assert property (!err_resp[0] |-> $stable(err_record[0]))
      else $error("error record changed without a fault");
   a_enable_update: assert property (enable_we |=> enabled == $past(enable_wdata))
      else $error("global enable not updated by write");
   // main scenarios reached
   c_sram_fault: cover property (enabled && err_resp[0]);
   c_bridge_pass: cover property (enabled && fwd_valid[1]);
   c_turn_on: cover property (enable_we && enable_wdata);
endmodule
bind bus_memory_protection_unit mpu_properties u_props (.core_clk(core_clk), .rst_n(rst_n),
   .enable_we(enable_we), .enable_wdata(enable_wdata), .enabled(enabled),
   .req_valid(req_valid), .req_addr(req_addr), .fwd_valid(fwd_valid), .fwd_addr(fwd_addr),
   .err_resp(err_resp), .err_logged(err_logged), .err_record(err_record));
`default_nettype wire

//--- crossbar_model.sv
// crossbar side model issuing single transfers on either slave lane
`timescale 1ns/100ps
`default_nettype none
module crossbar_model
   import mpu_pkg::*;
(
   // clock
   input wire logic core_clk,
   // request lanes
   output logic [NUM_PORTS-1:0] req_valid,
   output logic [NUM_PORTS-1:0][ADDR_W-1:0] req_addr,
   output logic [NUM_PORTS-1:0] req_write,
   output logic [NUM_PORTS-1:0] req_instr,
   output logic [NUM_PORTS-1:0] req_super,
   output logic [NUM_PORTS-1:0][MST_W-1:0] req_master,
   // answers
   input wire logic [NUM_PORTS-1:0] fwd_valid,
   input wire logic [NUM_PORTS-1:0] err_resp
);
   // lanes idle at time zero
   initial begin
      req_valid = '0;
      req_addr = '0;
      req_write = '0;
      req_instr = '0;
      req_super = '0;
      req_master = '0;
   end
   // one transfer, attributes scrambled once taken so stale values never help
   task automatic send(input int p, input logic [ADDR_W-1:0] a, input logic w, input logic f,
      input logic s, input logic [MST_W-1:0] m, output logic fw, output logic er);
      @(negedge core_clk);
      req_valid[p] = 1'b1;
      req_addr[p] = a;
      req_write[p] = w;
      req_instr[p] = f;
      req_super[p] = s;
      req_master[p] = m;
      @(negedge core_clk);
      req_valid[p] = 1'b0;
      req_addr[p] = ~a;
      req_write[p] = ~w;
      req_instr[p] = ~f;
      req_super[p] = ~s;
      req_master[p] = ~m;
      fw = fwd_valid[p];
      er = err_resp[p];
   endtask
endmodule
`default_nettype wire

//--- bus_memory_protection_unit_tb.sv
// self-checking bench for the memory protection unit
`timescale 1ns/100ps
`default_nettype none
module bus_memory_protection_unit_tb
   import mpu_pkg::*;
;
   // permission words built from the access word layout
   localparam logic [31:0] ACC0 = (32'h1 << ACC_SR) | (32'h1 << ACC_SX) | (32'h1 << ACC_NC_LSB);
   localparam logic [31:0] ACC15 = 32'h1 << (ACC_NC_LSB + 1);
   localparam logic [31:0] ACC_USER = 32'h1 << ACC_UR;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic enable_we = 1'b0, enable_wdata = 1'b0, enabled;
   logic cfg_we = 1'b0, cfg_alias = 1'b0, cfg_re = 1'b0;
   logic [3:0] cfg_desc = 4'h0;
   logic [1:0] cfg_word = 2'h0;
   logic [31:0] cfg_wdata = 32'h0, cfg_rdata;
   logic [1:0] req_valid, req_write, req_instr, req_super, fwd_valid, fwd_write, fwd_instr;
   logic [1:0] fwd_super, err_resp, err_logged;
   logic [1:0][31:0] req_addr, fwd_addr;
   logic [1:0][2:0] req_master, fwd_master;
   logic [1:0][63:0] err_record;
   int errors = 0;
   int comparisons = 0;
   logic [31:0] rd;
   logic [63:0] rec;
   bus_memory_protection_unit uut (.core_clk(core_clk), .rst_n(rst_n), .enable_we(enable_we),
      .enable_wdata(enable_wdata), .enabled(enabled), .cfg_we(cfg_we), .cfg_alias(cfg_alias),
      .cfg_desc(cfg_desc), .cfg_word(cfg_word), .cfg_wdata(cfg_wdata), .cfg_re(cfg_re),
      .cfg_rdata(cfg_rdata), .req_valid(req_valid), .req_addr(req_addr), .req_write(req_write),
      .req_instr(req_instr), .req_super(req_super), .req_master(req_master),
      .fwd_valid(fwd_valid), .fwd_addr(fwd_addr), .fwd_write(fwd_write), .fwd_instr(fwd_instr),
      .fwd_super(fwd_super), .fwd_master(fwd_master), .err_resp(err_resp),
      .err_logged(err_logged), .err_record(err_record));
   crossbar_model u_crossbar_switch (.core_clk(core_clk), .req_valid(req_valid), .req_addr(req_addr),
      .req_write(req_write), .req_instr(req_instr), .req_super(req_super),
      .req_master(req_master), .fwd_valid(fwd_valid), .err_resp(err_resp));
   // 50 MHz clock
   always #10 core_clk = ~core_clk;
   // verdict and end of run
   task automatic wrap_up();
      if (errors == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // one comparison
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // descriptor word write
   task automatic cfg_wr(input logic [3:0] d, input logic [1:0] w, input logic [31:0] v,
      input logic al);
      @(negedge core_clk);
      cfg_we = 1'b1;
      cfg_alias = al;
      cfg_desc = d;
      cfg_word = w;
      cfg_wdata = v;
      @(negedge core_clk);
      cfg_we = 1'b0;
   endtask
   // descriptor word read, data picked up half a cycle after the taking edge
   task automatic cfg_rd(input logic [3:0] d, input logic [1:0] w);
      @(negedge core_clk);
      cfg_re = 1'b1;
      cfg_alias = 1'b0;
      cfg_desc = d;
      cfg_word = w;
      @(negedge core_clk);
      cfg_re = 1'b0;
      rd = cfg_rdata;
   endtask
   // global enable write
   task automatic set_enable(input logic v);
      @(negedge core_clk);
      enable_we = 1'b1;
      enable_wdata = v;
      @(negedge core_clk);
      enable_we = 1'b0;
   endtask
   // one transfer, judged as forwarded or refused
   task automatic xfer(input int p, input logic [31:0] a, input logic w, input logic f,
      input logic s, input logic [2:0] m, input logic ok);
      logic fw, er;
      u_crossbar_switch.send(p, a, w, f, s, m, fw, er);
      check({fw, er}, {ok, !ok});
      if (ok) begin
         check(fwd_addr[p], a);
         check({fwd_master[p], fwd_super[p], fwd_instr[p], fwd_write[p]}, {m, s, f, w});
      end
   endtask
   // disabled out of reset: all passes on both lanes
   task automatic t_disabled();
      check(enabled, 1'b0);
      xfer(0, 32'h0000_0040, 1'b1, 1'b0, 1'b0, MST_CORE_D, 1'b1);
      xfer(1, 32'hc000_0000, 1'b0, 1'b0, 1'b0, MST_EXT, 1'b1);
      check(err_logged, 2'h0);
   endtask
   // program lowest and highest descriptors over one range
   task automatic t_program();
      cfg_wr(4'h0, WORD_START, 32'h0000_1000, 1'b0);
      cfg_wr(4'h0, WORD_END, 32'h0000_1fe0, 1'b0);
      cfg_wr(4'h0, WORD_ACC, ACC0, 1'b0);
      cfg_wr(4'h0, WORD_VALID, 32'h1, 1'b0);
      cfg_wr(4'hf, WORD_START, 32'h0000_1000, 1'b0);
      cfg_wr(4'hf, WORD_END, 32'h0000_1fe0, 1'b0);
      cfg_wr(4'hf, WORD_ACC, ACC15, 1'b0);
      cfg_wr(4'hf, WORD_VALID, 32'h1, 1'b0);
      cfg_rd(4'h0, WORD_END);
      check(rd, 32'h0000_1fff);
      cfg_rd(4'hf, WORD_VALID);
      check(rd[0], 1'b1);
      set_enable(1'b1);
      check(enabled, 1'b1);
   endtask
   // inclusive bounds, unmapped faults and the record contents
   task automatic t_bounds();
      xfer(0, 32'h0000_1000, 1'b0, 1'b0, 1'b1, MST_CORE_D, 1'b1);
      xfer(0, 32'h0000_1fff, 1'b0, 1'b0, 1'b1, MST_CORE_D, 1'b1);
      xfer(0, 32'h0000_0ffc, 1'b0, 1'b0, 1'b1, MST_CORE_D, 1'b0);
      xfer(1, 32'h0000_2000, 1'b1, 1'b0, 1'b1, MST_CORE_D, 1'b0);
      check(err_record[1], {16'h0, 10'h0, MST_CORE_D, 3'b101, 32'h0000_2000});
   endtask
   // core permissions split by mode, other masters read and write only
   task automatic t_perm();
      xfer(0, 32'h0000_1800, 1'b0, 1'b1, 1'b1, MST_CORE_I, 1'b1);
      xfer(0, 32'h0000_1800, 1'b1, 1'b0, 1'b1, MST_CORE_D, 1'b0);
      xfer(0, 32'h0000_1010, 1'b0, 1'b0, 1'b0, MST_CORE_D, 1'b0);
      check(err_record[0], {16'h8001, 10'h0, MST_CORE_D, 3'b000, 32'h0000_1010});
      xfer(1, 32'h0000_1020, 1'b0, 1'b0, 1'b0, MST_DMA, 1'b1);
      xfer(1, 32'h0000_1020, 1'b1, 1'b0, 1'b0, MST_DMA, 1'b1);
      xfer(1, 32'h0000_1020, 1'b0, 1'b0, 1'b0, MST_NET, 1'b0);
      xfer(1, 32'h0000_1020, 1'b1, 1'b0, 1'b0, MST_EXT, 1'b0);
   endtask
   // alias rewrite of rights only, then a normal write drops validity
   task automatic t_alias();
      cfg_wr(4'h0, WORD_START, ACC_USER, 1'b1);
      cfg_rd(4'h0, WORD_START);
      check(rd[31:5], 27'h0000080);
      cfg_rd(4'h0, WORD_VALID);
      check(rd[0], 1'b1);
      rec = err_record[0];
      xfer(0, 32'h0000_1010, 1'b0, 1'b0, 1'b0, MST_CORE_D, 1'b1);
      check(err_record[0], rec);
      xfer(0, 32'h0000_1010, 1'b0, 1'b0, 1'b1, MST_CORE_D, 1'b0);
      cfg_wr(4'h0, WORD_ACC, ACC_USER, 1'b0);
      cfg_rd(4'h0, WORD_VALID);
      check(rd[0], 1'b0);
      xfer(0, 32'h0000_1010, 1'b0, 1'b0, 1'b0, MST_CORE_D, 1'b0);
      check(err_logged, 2'h3);
   endtask
   // main sequence
   initial begin
      repeat (6) @(posedge core_clk);
      @(negedge core_clk);
      rst_n = 1'b1;
      t_disabled();
      t_program();
      t_bounds();
      t_perm();
      t_alias();
      wrap_up();
   end
   // hang guard, far beyond the roughly 70 cycles the tests need
   initial begin
      #200000;
      errors++;
      wrap_up();
   end
endmodule
`default_nettype wire
